// >>> dv/lppl_pen_model.sv
// light pen photodetector model
`default_nettype none

module lppl_pen_model (
  // clock and hit request
  input wire logic clk_i,
  input wire logic hit_i,
  // pen pin, idle high
  output logic pen_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_reg = 4'h0;
  // pulls the pin low for eight cycles per hit
  always_ff @(posedge clk_i) begin
    if (hit_i)
      cnt_reg <= 4'h8;
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end
  assign pen_n_o = (cnt_reg == 4'h0);
endmodule : lppl_pen_model

`default_nettype wire

// >>> dv/tb_light_pen_position_latch.sv
// testbench of the pen position latch
`default_nettype none

module tb_light_pen_position_latch;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hit = 1'b0;
  wire logic pen_n;
  lppl_pkg::lppl_beam_t beam_i = {9'h000, 9'h1c3};
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [17:0] adr_i = 18'h0_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic capture_o;
  logic [31:0] caps = 32'h0000_0000;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 clk_i = ~clk_i;

  lppl_top dut (.clk_i(clk_i), .rst_i(rst_i), .pen_n_i(pen_n), .beam_i(beam_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
    .dat_i(32'hffff_ffff), .dat_o(dat_o), .ack_o(ack_o), .capture_o(capture_o));
  lppl_pen_model pen (.clk_i(clk_i), .hit_i(hit), .pen_n_o(pen_n));

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (capture_o === 1'b1)
      caps <= caps + 32'h0000_0001;
    if (cycles == 3000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic [17:0] a, input logic w, output logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    d = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd2(input logic [7:0] ex, input logic [7:0] ey);
    logic [31:0] d;
    wb(lppl_pkg::PEN_X_CAPTURE_ADDR, 1'b0, d);
    chk("pen_x", {24'h00_0000, ex}, d);
    wb(lppl_pkg::PEN_Y_CAPTURE_ADDR, 1'b0, d);
    chk("pen_y", {24'h00_0000, ey}, d);
  endtask : rd2

  task automatic rd_stat(input logic [31:0] e);
    logic [31:0] d;
    wb(lppl_pkg::PEN_STATUS_ADDR, 1'b0, d);
    chk("status", e, d);
  endtask : rd_stat

  task automatic fire();
    hit <= 1'b1;
    @(posedge clk_i);
    hit <= 1'b0;
    repeat (14) @(posedge clk_i);
  endtask : fire

  task automatic t_capture();
    logic [31:0] d;
    rd_stat(32'h0000_0001);
    rd2(8'h00, 8'h00);
    wb(18'h0_0000, 1'b0, d);
    chk("unmapped", 32'h0000_0000, d);
    beam_i <= {9'h1a5, 9'h1c3};
    fire();
    chk("captures", 32'h0000_0001, caps);
    rd2(8'hd2, 8'hc3);
    rd_stat(32'h0000_0002);
    wb(lppl_pkg::PEN_X_CAPTURE_ADDR, 1'b1, d);
    rd2(8'hd2, 8'hc3);
  endtask : t_capture

  task automatic t_refuse();
    beam_i <= {9'h0ff, 9'h111};
    fire();
    fire();
    chk("captures", 32'h0000_0001, caps);
    rd2(8'hd2, 8'hc3);
    rd_stat(32'h0000_0002);
  endtask : t_refuse

  task automatic t_rearm();
    beam_i <= {9'h0ff, 9'h000};
    repeat (3) @(posedge clk_i);
    rd_stat(32'h0000_0003);
    beam_i <= {9'h003, 9'h010};
    fire();
    chk("captures", 32'h0000_0002, caps);
    rd2(8'h01, 8'h10);
    rd_stat(32'h0000_0002);
  endtask : t_rearm

  task automatic t_reset();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_stat(32'h0000_0001);
    rd2(8'h00, 8'h00);
    beam_i <= {9'h0ff, 9'h111};
    fire();
    chk("captures", 32'h0000_0003, caps);
    rd2(8'h7f, 8'h11);
    rd_stat(32'h0000_0002);
  endtask : t_reset

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_capture();
    t_refuse();
    t_rearm();
    t_reset();
    test_done();
  end
endmodule : tb_light_pen_position_latch

`default_nettype wire

// >>> hdl/lppl_pkg.sv
// package: register map, field layout and timing constants of the pen position latch
`default_nettype none

package lppl_pkg;

  // ***************************************
  // register map
  // ***************************************
  // offsets are word indices: byte address is four times the index
  localparam logic [15:0] PEN_X_CAPTURE_IDX = 16'hd013;
  localparam logic [15:0] PEN_Y_CAPTURE_IDX = 16'hd014;
  localparam logic [15:0] PEN_STATUS_IDX = 16'hd015;
  localparam int ADDR_W = 18;
  localparam logic [17:0] PEN_X_CAPTURE_ADDR = {PEN_X_CAPTURE_IDX, 2'b00};
  localparam logic [17:0] PEN_Y_CAPTURE_ADDR = {PEN_Y_CAPTURE_IDX, 2'b00};
  localparam logic [17:0] PEN_STATUS_ADDR = {PEN_STATUS_IDX, 2'b00};

  // ***************************************
  // field layout and reset values
  // ***************************************
  localparam int HPOS_W = 9;
  localparam int VPOS_W = 9;
  localparam int CAP_W = 8;
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam logic [7:0] CAP_RESET = 8'h00;
  // raster line at which capture is re-armed each frame
  localparam logic [8:0] REARM_LINE = 9'h000;

  // ***************************************
  // carrier types
  // ***************************************
  typedef struct packed {
    logic [8:0] hpos;
    logic [8:0] vpos;
  } lppl_beam_t;

  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
  } lppl_capture_t;

  typedef enum logic {
    LPPL_BUS_IDLE,
    LPPL_BUS_ACK
  } lppl_bus_state_t;

endpackage : lppl_pkg

`default_nettype wire

// >>> hdl/lppl_top.sv
// module: light pen position latch with classic wishbone register slave
`default_nettype none

// ***************************************
// position latch
// ***************************************
// Notes on behaviour
// - a high to low edge on the pen input copies the beam coordinates into both pen registers.
// - the horizontal register holds the eight upper bits of the horizontal position at the edge.
// - the nine bit horizontal count loses its lowest bit, giving two dot resolution.
// - the vertical register holds an eight bit raster line value taken at the edge.
// - only one capture is accepted per frame unless one lands in the re-arm pulse cycle, which keeps the latch armed; while disarmed, edges change nothing.
module lppl_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // light pen pin, active low
  input wire logic pen_n_i,
  // beam position from display timing
  input wire lppl_pkg::lppl_beam_t beam_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [lppl_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // capture strobe
  output logic capture_o
);

  // ***************************************
  // pen synchroniser and edge detect
  // ***************************************
  logic pen_meta_reg;
  logic pen_sync_reg;
  logic pen_prev_reg;
  logic pen_fall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pen_meta_reg <= 1'b1;
      pen_sync_reg <= 1'b1;
      pen_prev_reg <= 1'b1;
    end else begin
      pen_meta_reg <= pen_n_i;
      pen_sync_reg <= pen_meta_reg;
      pen_prev_reg <= pen_sync_reg;
    end
  end

  assign pen_fall = pen_prev_reg & ~pen_sync_reg;

  // ***************************************
  // capture state
  // ***************************************
  logic armed_reg;
  logic armed_next;
  logic valid_reg;
  logic valid_next;
  logic rearm_point;
  logic line_prev_zero_reg;
  logic take;
  lppl_pkg::lppl_capture_t cap_reg;
  lppl_pkg::lppl_capture_t cap_next;

  // one pulse at the start of the re-arm line
  assign rearm_point = (beam_i.vpos == lppl_pkg::REARM_LINE) & ~line_prev_zero_reg;
  assign take = pen_fall & armed_reg;

  always_comb begin
    armed_next = armed_reg;
    valid_next = valid_reg;
    cap_next = cap_reg;
    if (take) begin
      cap_next.x = beam_i.hpos[lppl_pkg::HPOS_W-1:1];
      cap_next.y = beam_i.vpos[lppl_pkg::CAP_W-1:0];
      armed_next = 1'b0;
      valid_next = 1'b1;
    end
    if (rearm_point) begin
      armed_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_reg <= 1'b1;
      valid_reg <= 1'b0;
      cap_reg <= '{x: lppl_pkg::CAP_RESET, y: lppl_pkg::CAP_RESET};
      line_prev_zero_reg <= 1'b0;
      capture_o <= 1'b0;
    end else begin
      armed_reg <= armed_next;
      valid_reg <= valid_next;
      cap_reg <= cap_next;
      line_prev_zero_reg <= (beam_i.vpos == lppl_pkg::REARM_LINE);
      capture_o <= take;
    end
  end

  // ***************************************
  // wishbone slave
  // ***************************************
  lppl_pkg::lppl_bus_state_t bus_reg;
  lppl_pkg::lppl_bus_state_t bus_next;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;

  always_comb begin
    bus_next = lppl_pkg::LPPL_BUS_IDLE;
    rdata_next = rdata_reg;
    case (bus_reg)
      lppl_pkg::LPPL_BUS_IDLE: begin
        if (cyc_i && stb_i) begin
          bus_next = lppl_pkg::LPPL_BUS_ACK;
          rdata_next = 32'h0000_0000;
          if (!we_i) begin
            case (adr_i)
              lppl_pkg::PEN_X_CAPTURE_ADDR: rdata_next = {24'h00_0000, cap_reg.x};
              lppl_pkg::PEN_Y_CAPTURE_ADDR: rdata_next = {24'h00_0000, cap_reg.y};
              lppl_pkg::PEN_STATUS_ADDR: begin
                rdata_next[lppl_pkg::STAT_ARMED_BIT] = armed_reg;
                rdata_next[lppl_pkg::STAT_VALID_BIT] = valid_reg;
              end
              default: rdata_next = 32'h0000_0000;
            endcase
          end
        end
      end
      lppl_pkg::LPPL_BUS_ACK: bus_next = lppl_pkg::LPPL_BUS_IDLE;
      default: bus_next = lppl_pkg::LPPL_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_reg <= lppl_pkg::LPPL_BUS_IDLE;
      rdata_reg <= 32'h0000_0000;
    end else begin
      bus_reg <= bus_next;
      rdata_reg <= rdata_next;
    end
  end

  assign ack_o = (bus_reg == lppl_pkg::LPPL_BUS_ACK);
  assign dat_o = rdata_reg;

  // ***************************************
  // checks
  // ***************************************
  property p_capture_x;
    @(posedge clk_i) disable iff (rst_i)
      take |=> cap_reg.x == $past(beam_i.hpos[8:1]);
  endproperty
  a_capture_x: assert property (p_capture_x) else $error("x capture wrong");

  property p_capture_y;
    @(posedge clk_i) disable iff (rst_i)
      take |=> cap_reg.y == $past(beam_i.vpos[7:0]);
  endproperty
  a_capture_y: assert property (p_capture_y) else $error("y capture wrong");

  property p_fall_armed_captures;
    @(posedge clk_i) disable iff (rst_i)
      (pen_prev_reg && !pen_sync_reg && armed_reg) |=> capture_o;
  endproperty
  a_fall_armed_captures: assert property (p_fall_armed_captures) else $error("edge missed");

  property p_lowest_bit_dropped;
    @(posedge clk_i) disable iff (rst_i)
      take |=> {cap_reg.x, $past(beam_i.hpos[0])} == $past(beam_i.hpos);
  endproperty
  a_lowest_bit_dropped: assert property (p_lowest_bit_dropped) else $error("x resolution");

  property p_one_per_frame;
    @(posedge clk_i) disable iff (rst_i)
      (!armed_reg && !rearm_point) |=> $stable(cap_reg);
  endproperty
  a_one_per_frame: assert property (p_one_per_frame) else $error("second capture");

  property p_disarm;
    @(posedge clk_i) disable iff (rst_i)
      (take && !rearm_point) |=> !armed_reg;
  endproperty
  a_disarm: assert property (p_disarm) else $error("not disarmed");

  property p_rearm;
    @(posedge clk_i) disable iff (rst_i)
      rearm_point |=> armed_reg;
  endproperty
  a_rearm: assert property (p_rearm) else $error("not re-armed");

  property p_arm_only_at_line;
    @(posedge clk_i) disable iff (rst_i)
      (!armed_reg && !rearm_point) |=> !armed_reg;
  endproperty
  a_arm_only_at_line: assert property (p_arm_only_at_line) else $error("stray re-arm");

  property p_strobe_only_on_take;
    @(posedge clk_i) disable iff (rst_i)
      capture_o |-> $past(take);
  endproperty
  a_strobe_only_on_take: assert property (p_strobe_only_on_take) else $error("stray strobe");

  property p_ack_one_cycle;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("ack too long");

  property p_x_read;
    @(posedge clk_i) disable iff (rst_i)
      (bus_reg == lppl_pkg::LPPL_BUS_IDLE && cyc_i && stb_i && !we_i &&
        adr_i == lppl_pkg::PEN_X_CAPTURE_ADDR) |=> dat_o == {24'h00_0000, $past(cap_reg.x)};
  endproperty
  a_x_read: assert property (p_x_read) else $error("x read data wrong");

endmodule : lppl_top

`default_nettype wire
